// *** sbsc_regs.vh ***
`ifndef SBSC_REGS_VH
`define SBSC_REGS_VH

// ----------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------
`define SBSC_IDX_CTRL_ONE 14'h1240
`define SBSC_IDX_STATUS 14'h1243
`define SBSC_IDX_RATE0 14'h1244
`define SBSC_IDX_RATE1 14'h1245

// ----------------------------------------------------------------------
// Field positions of the status view and control register 2.
// ----------------------------------------------------------------------
`define SBSC_BIT_MASTER 7
`define SBSC_BIT_TRANSMIT 6
`define SBSC_BIT_BUSY 5
`define SBSC_BIT_PENDING_N 4
`define SBSC_BIT_ARB_LOST 3
`define SBSC_BIT_ADDR_HIT 2
`define SBSC_BIT_BCAST_HIT 1
`define SBSC_BIT_LAST_RX 0
`define SBSC_BIT_XFER_ACTIVE 3
`define SBSC_BIT_SHIFT_ACTIVE 2
`define SBSC_BIT_START_STOP 5
`define SBSC_MODE_HI 3
`define SBSC_MODE_LO 2
`define SBSC_KEY_HI 1
`define SBSC_KEY_LO 0

// ----------------------------------------------------------------------
// Control register 1 and baud register fields.
// ----------------------------------------------------------------------
`define SBSC_BIT_SHIFT_GO 7
`define SBSC_BIT_SHIFT_ABORT 6
`define SBSC_XMODE_HI 5
`define SBSC_XMODE_LO 4
`define SBSC_BIT_IDLE_RUN 6
`define SBSC_BIT_CLOCK_ON 7

// ----------------------------------------------------------------------
// Encodings and reset values.
// ----------------------------------------------------------------------
`define SBSC_OPM_PORT 2'h0
`define SBSC_OPM_SHIFT 2'h1
`define SBSC_OPM_TWI 2'h2
`define SBSC_OPM_RSVD 2'h3
`define SBSC_XM_TX 2'h0
`define SBSC_XM_RSVD 2'h1
`define SBSC_XM_TXRX 2'h2
`define SBSC_XM_RX 2'h3
`define SBSC_KEY_FIRST 2'h2
`define SBSC_KEY_SECOND 2'h1
`define SBSC_RST_OPM 2'h0
`define SBSC_RST_XMODE 2'h0
`define SBSC_RST_PENDING_N 1'h1
`define SBSC_RST_FLAG 1'h0

`endif

// *** sbsc_reset_key.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_regs.vh"

module sbsc_reset_key
(
    input wire clk,
    input wire rstn,
    input wire key_wr,
    input wire [1:0] key_val,
    output reg fire_reg
);
    // ------------------------------------------------------------------
    // Two-step key sequencer.
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_ARMED = 2'h2;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg fire_next;

    // Any control-two write other than the second key or a repeated first key drops the arming, so a stray write cannot complete the pair.
    always @*
    begin
        state_next = state_reg;
        fire_next = 1'b0;
        if (key_wr)
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (key_val == `SBSC_KEY_FIRST)
                        state_next = ST_ARMED; // see (RQ6)
                end
                ST_ARMED:
                begin
                    if (key_val == `SBSC_KEY_SECOND)
                    begin
                        fire_next = 1'b1; // see (RQ6)
                        state_next = ST_IDLE;
                    end
                    else if (key_val != `SBSC_KEY_FIRST)
                        state_next = ST_IDLE;
                end
                default:
                    state_next = ST_IDLE;
            endcase
        end
    end

    // State and pulse flops.
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            fire_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            fire_reg <= fire_next;
        end
    end
endmodule // sbsc_reset_key

`default_nettype wire

// *** sbsc_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_regs.vh"

// Contract
// (RQ1) Shared offset: read gives status view, write loads control register two.
// (RQ2) Two-wire status bits 7..4: master, transmit, busy, pending-not; pending-not resets high.
// (RQ3) Arbitration lost, address hit, broadcast hit set on detection; last received bit shown.
// (RQ4) Two-wire write of start/stop field: one makes start, zero makes stop.
// (RQ5) Mode field: 00 port, 01 shift serial, 10 two-wire, 11 reserved.
// (RQ6) Writing key 10 then 01 generates an internal interface reset.
// (RQ7) Shift mode status bits 3 and 2 show transfer and shift in progress.
// (RQ8) Idle-run bit decides whether the interface runs during low-power idle.
// (RQ9) Software writes zero to rate zero bit 7 and shift-mode low bits.
// (RQ10) Clock-on bit gates the internal baud clock; bit 6 written zero.
// (RQ11) Shift transfer mode: 00 transmit, 10 transmit/receive, 11 receive, 01 reserved.
// (RQ12) Bus event request asserted while pending-not is low.
module sbsc_top
(
    input wire clk,
    input wire rstn,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire core_master,
    input wire core_transmit,
    input wire core_bus_busy,
    input wire core_byte_done,
    input wire ev_arb_lost,
    input wire ev_addr_match,
    input wire ev_general_call,
    input wire rx_bit_strobe,
    input wire rx_bit,
    input wire shift_xfer_busy,
    input wire shift_busy,
    input wire low_power_idle_state,
    output reg start_req,
    output reg stop_req,
    output reg [1:0] op_mode,
    output reg iface_reset,
    output reg bus_event_irq,
    output reg shift_go,
    output reg shift_abort,
    output reg [1:0] shift_xfer_mode,
    output reg baud_clk_en,
    output reg iface_run
);
    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------
    wire bus_req;
    wire wr_ok;
    wire [13:0] idx;
    wire hit_ctrl1;
    wire hit_status;
    wire hit_rate0;
    wire hit_rate1;
    wire wr_ctrl1;
    wire wr_ctrl2;
    wire wr_rate0;
    wire wr_rate1;
    wire key_fire;
    wire [7:0] wbyte;

    // Status view and control two share one index. A read-modify-write there would copy
    // status bits back as control bits, and the logic cannot tell such a write from a plain one.
    // A request is served once; the second cycle of the pair only drops ack.
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ok = bus_req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[15:2];
    assign wbyte = wb_dat_i[7:0];
    assign hit_ctrl1 = (idx == `SBSC_IDX_CTRL_ONE);
    assign hit_status = (idx == `SBSC_IDX_STATUS);
    assign hit_rate0 = (idx == `SBSC_IDX_RATE0);
    assign hit_rate1 = (idx == `SBSC_IDX_RATE1);
    assign wr_ctrl1 = wr_ok & hit_ctrl1;
    assign wr_ctrl2 = wr_ok & hit_status; // see (RQ1)
    assign wr_rate0 = wr_ok & hit_rate0;
    assign wr_rate1 = wr_ok & hit_rate1;

    // ------------------------------------------------------------------
    // Stored state.
    // ------------------------------------------------------------------
    reg master_flag_reg;
    reg transmit_flag_reg;
    reg bus_busy_flag_reg;
    reg pending_not_flag_reg;
    reg arbitration_lost_flag_reg;
    reg addressed_as_slave_flag_reg;
    reg broadcast_hit_flag_reg;
    reg last_rx_bit_reg;
    reg shift_transfer_active_reg;
    reg shifter_active_reg;
    reg idle_run_sel_reg;
    reg divider_clock_on_reg;
    reg [1:0] op_mode_reg;
    reg [1:0] op_mode_next;
    reg [7:0] status_view;

    // Two-wire mode gates both the event flags and the start/stop pulses, so the test is shared.
    function is_twi;
        input [1:0] m;
        begin
            is_twi = (m == `SBSC_OPM_TWI);
        end
    endfunction

    // The reserved mode code keeps the previous mode rather than entering an undefined one.
    always @*
    begin
        op_mode_next = op_mode_reg;
        if (wr_ctrl2 && wbyte[`SBSC_MODE_HI:`SBSC_MODE_LO] != `SBSC_OPM_RSVD)
            op_mode_next = wbyte[`SBSC_MODE_HI:`SBSC_MODE_LO]; // see (RQ5)
    end

    // Soft reset key sequencer. Its pulse clears the status flags at the next edge; the outer
    // reset output is registered from the same pulse, so it rises on that same edge as the clear.
    // The key only clears status; mode, control one and the rate bits survive it.
    sbsc_reset_key u_key
    (
        .clk(clk),
        .rstn(rstn),
        .key_wr(wr_ctrl2),
        .key_val(wbyte[`SBSC_KEY_HI:`SBSC_KEY_LO]),
        .fire_reg(key_fire)
    );

    // ------------------------------------------------------------------
    // Status flags.
    // ------------------------------------------------------------------
    // Detection sets win over a clear written in the same cycle, so no event is lost.
    // Role and busy bits are plain copies of the engine levels and need no clear.
    // The last received bit keeps its value until the next strobe or a key reset, even across a mode change.
    always @(posedge clk)
    begin
        if (!rstn || key_fire)
        begin
            master_flag_reg <= `SBSC_RST_FLAG;
            transmit_flag_reg <= `SBSC_RST_FLAG;
            bus_busy_flag_reg <= `SBSC_RST_FLAG;
            pending_not_flag_reg <= `SBSC_RST_PENDING_N;
            arbitration_lost_flag_reg <= `SBSC_RST_FLAG;
            addressed_as_slave_flag_reg <= `SBSC_RST_FLAG;
            broadcast_hit_flag_reg <= `SBSC_RST_FLAG;
            last_rx_bit_reg <= `SBSC_RST_FLAG;
            shift_transfer_active_reg <= `SBSC_RST_FLAG;
            shifter_active_reg <= `SBSC_RST_FLAG;
        end
        else
        begin
            master_flag_reg <= core_master; // see (RQ2)
            transmit_flag_reg <= core_transmit; // see (RQ2)
            bus_busy_flag_reg <= core_bus_busy; // see (RQ2)
            if (core_byte_done)
                pending_not_flag_reg <= 1'b0; // see (RQ2)
            else if (wr_ctrl2)
                pending_not_flag_reg <= 1'b1;
            if (is_twi(op_mode_reg) && ev_arb_lost)
                arbitration_lost_flag_reg <= 1'b1; // see (RQ3)
            else if (wr_ctrl2)
                arbitration_lost_flag_reg <= 1'b0;
            if (is_twi(op_mode_reg) && ev_addr_match)
                addressed_as_slave_flag_reg <= 1'b1; // see (RQ3)
            else if (wr_ctrl2)
                addressed_as_slave_flag_reg <= 1'b0;
            if (is_twi(op_mode_reg) && ev_general_call)
                broadcast_hit_flag_reg <= 1'b1; // see (RQ3)
            else if (wr_ctrl2)
                broadcast_hit_flag_reg <= 1'b0;
            if (rx_bit_strobe)
                last_rx_bit_reg <= rx_bit; // see (RQ3)
            shift_transfer_active_reg <= shift_xfer_busy; // see (RQ7)
            shifter_active_reg <= shift_busy; // see (RQ7)
        end
    end

    // Status view layout follows the current mode; in shift mode unused bits read zero.
    // The view is combinational; the bus answer registers it as it stands at the commit edge.
    always @*
    begin
        status_view = 8'h00;
        if (op_mode_reg == `SBSC_OPM_SHIFT)
        begin
            status_view[`SBSC_BIT_XFER_ACTIVE] = shift_transfer_active_reg; // see (RQ7)
            status_view[`SBSC_BIT_SHIFT_ACTIVE] = shifter_active_reg; // see (RQ7)
        end
        else
        begin
            status_view[`SBSC_BIT_MASTER] = master_flag_reg;
            status_view[`SBSC_BIT_TRANSMIT] = transmit_flag_reg;
            status_view[`SBSC_BIT_BUSY] = bus_busy_flag_reg;
            status_view[`SBSC_BIT_PENDING_N] = pending_not_flag_reg;
            status_view[`SBSC_BIT_ARB_LOST] = arbitration_lost_flag_reg;
            status_view[`SBSC_BIT_ADDR_HIT] = addressed_as_slave_flag_reg;
            status_view[`SBSC_BIT_BCAST_HIT] = broadcast_hit_flag_reg;
            status_view[`SBSC_BIT_LAST_RX] = last_rx_bit_reg;
        end
    end

    // ------------------------------------------------------------------
    // Control registers and command pulses.
    // ------------------------------------------------------------------
    // Start and stop are only issued when the mode after the write is two-wire.
    // The reserved transfer-mode code keeps the old code, as the reserved operating mode does.
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            op_mode_reg <= `SBSC_RST_OPM;
            start_req <= 1'b0;
            stop_req <= 1'b0;
            iface_reset <= 1'b0;
            shift_go <= 1'b0;
            shift_abort <= 1'b0;
            shift_xfer_mode <= `SBSC_RST_XMODE;
            idle_run_sel_reg <= 1'b0;
            divider_clock_on_reg <= 1'b0;
        end
        else
        begin
            op_mode_reg <= op_mode_next;
            start_req <= wr_ctrl2 & is_twi(op_mode_next) & wbyte[`SBSC_BIT_START_STOP]; // see (RQ4)
            stop_req <= wr_ctrl2 & is_twi(op_mode_next) & ~wbyte[`SBSC_BIT_START_STOP]; // see (RQ4)
            iface_reset <= key_fire; // see (RQ6)
            if (wr_ctrl1)
            begin
                shift_go <= wbyte[`SBSC_BIT_SHIFT_GO];
                shift_abort <= wbyte[`SBSC_BIT_SHIFT_ABORT];
                if (wbyte[`SBSC_XMODE_HI:`SBSC_XMODE_LO] != `SBSC_XM_RSVD)
                    shift_xfer_mode <= wbyte[`SBSC_XMODE_HI:`SBSC_XMODE_LO]; // see (RQ11)
            end
            // Bit 7 of rate zero and bit 6 of rate one are not stored; they read zero.
            if (wr_rate0)
                idle_run_sel_reg <= wbyte[`SBSC_BIT_IDLE_RUN]; // see (RQ8)
            if (wr_rate1)
                divider_clock_on_reg <= wbyte[`SBSC_BIT_CLOCK_ON]; // see (RQ10)
        end
    end

    // ------------------------------------------------------------------
    // Run enables, request and outputs.
    // ------------------------------------------------------------------
    // The idle level comes from the chip on this same clock, so it needs no synchroniser.
    // Leaving idle with idle-run clear restarts the interface one cycle later.
    wire run_next;
    assign run_next = ~low_power_idle_state | idle_run_sel_reg; // see (RQ8)

    // Outputs are registered, so they lag the controlling bits by one cycle.
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            op_mode <= `SBSC_RST_OPM;
            bus_event_irq <= 1'b0;
            baud_clk_en <= 1'b0;
            iface_run <= 1'b0;
        end
        else
        begin
            op_mode <= op_mode_reg;
            bus_event_irq <= ~pending_not_flag_reg; // see (RQ12)
            baud_clk_en <= divider_clock_on_reg & run_next; // see (RQ10)
            iface_run <= run_next;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone answer.
    // ------------------------------------------------------------------
    // Every address is acknowledged; unmapped or write-only reads return zero.
    // Ack is never given two cycles running, so the master may release on the ack edge.
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                wb_dat_o <= 32'h00000000;
                if (hit_status)
                    wb_dat_o[7:0] <= status_view; // see (RQ1)
                else if (hit_rate0)
                    wb_dat_o[`SBSC_BIT_IDLE_RUN] <= idle_run_sel_reg;
                else if (hit_rate1)
                    wb_dat_o[`SBSC_BIT_CLOCK_ON] <= divider_clock_on_reg;
            end
        end
    end
endmodule // sbsc_top

`default_nettype wire

// *** sbsc_checker_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_regs.vh"

// ----------------------------------------------------------------------
// Bus handshake, control pulses and run enables
// ----------------------------------------------------------------------
module sbsc_checker
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic core_byte_done,
    input wire logic low_power_idle_state,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic [1:0] op_mode,
    input wire logic iface_reset,
    input wire logic bus_event_irq,
    input wire logic baud_clk_en,
    input wire logic iface_run
);
    // A control-two write taken at this edge; the second key half is a special case of it.
    wire logic wr2 = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[15:2] == `SBSC_IDX_STATUS;
    wire logic key2 = wr2 && wb_dat_i[1:0] == `SBSC_KEY_SECOND;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acked in the next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_start_cause: assert property (start_req |-> $past(wr2 && wb_dat_i[5]))
        else $error("start issued without a start write");
    a_stop_cause: assert property (stop_req |-> $past(wr2 && !wb_dat_i[5]))
        else $error("stop issued without a stop write");
    a_mode_by_write: assert property ($changed(op_mode) |-> $past(wr2) || $past(wr2, 2))
        else $error("mode changed without a control write");
    a_irq_from_done: assert property (core_byte_done |-> ##2 bus_event_irq)
        else $error("bus event request missing after byte done");
    a_key_pulse: assert property (iface_reset |-> ($past(key2, 2) || $past(key2, 3)) ##1 !iface_reset)
        else $error("interface reset not a single pulse after key");
    a_run_awake: assert property (($past(rstn) && !$past(low_power_idle_state)) |-> iface_run)
        else $error("interface stopped outside idle");
    a_clock_gate: assert property (baud_clk_en |-> iface_run)
        else $error("baud clock running while interface stopped");
endmodule // sbsc_checker

bind sbsc_top sbsc_checker chk_u (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .core_byte_done(core_byte_done), .low_power_idle_state(low_power_idle_state), .start_req(start_req),
    .stop_req(stop_req), .op_mode(op_mode), .iface_reset(iface_reset), .bus_event_irq(bus_event_irq),
    .baud_clk_en(baud_clk_en), .iface_run(iface_run));
`default_nettype wire

// *** sbsc_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Bus engine stand-in: owns the bus after start, reports one byte later
// ----------------------------------------------------------------------
module sbsc_peer_model
#(
    parameter int BYTE_CYC = 12
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic iface_reset,
    input wire logic shift_go,
    input wire logic shift_abort,
    input wire logic [1:0] op_mode,
    output var logic core_master = 1'b0,
    output var logic core_transmit = 1'b0,
    output var logic core_bus_busy = 1'b0,
    output var logic core_byte_done = 1'b0,
    output var logic shift_xfer_busy = 1'b0,
    output var logic shift_busy = 1'b0
);
    int cnt = 0;

    // The byte takes several cycles, so the status is seen busy before it is seen done.
    always @(posedge clk)
    begin
        core_byte_done <= 1'b0;
        if (!rstn || iface_reset || stop_req)
        begin
            {core_master, core_transmit, core_bus_busy} <= 3'h0;
            cnt <= 0;
        end
        else if (start_req)
        begin
            {core_master, core_transmit, core_bus_busy} <= 3'h7;
            cnt <= BYTE_CYC;
        end
        else if (cnt != 0)
        begin
            cnt <= cnt - 1;
            core_byte_done <= (cnt == 1);
        end
        shift_xfer_busy <= rstn && op_mode == 2'h1 && shift_go && !shift_abort;
        shift_busy <= rstn && op_mode == 2'h1 && shift_go && !shift_abort;
    end
endmodule // sbsc_peer_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Register bus driven tests of the status and control logic
// ----------------------------------------------------------------------
module testbench;
    logic clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, rx_bit = 0, rx_bit_strobe = 0;
    logic ev_arb_lost = 0, ev_addr_match = 0, ev_general_call = 0, low_power_idle_state = 0;
    logic [15:0] wb_adr_i = 16'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, seed = 32'h6e044fe3, rnd;
    logic [7:0] rd;
    logic [3:0] e;
    logic [1:0] xm;
    logic [3:0] sel_v = 4'h1;
    logic [1:0] st_codes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int error_cnt = 0, check_count = 0, cyc_cnt = 0, n_start = 0, n_stop = 0, n_rst = 0, s;
    wire [31:0] wb_dat_o;
    wire [1:0] op_mode, shift_xfer_mode;
    wire wb_ack_o, start_req, stop_req, iface_reset, bus_event_irq, shift_go, shift_abort, baud_clk_en, iface_run;
    wire core_master, core_transmit, core_bus_busy, core_byte_done, shift_xfer_busy, shift_busy;

    sbsc_top dut_u (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .core_master(core_master), .core_transmit(core_transmit), .core_bus_busy(core_bus_busy),
        .core_byte_done(core_byte_done), .ev_arb_lost(ev_arb_lost), .ev_addr_match(ev_addr_match),
        .ev_general_call(ev_general_call), .rx_bit_strobe(rx_bit_strobe), .rx_bit(rx_bit),
        .shift_xfer_busy(shift_xfer_busy), .shift_busy(shift_busy), .low_power_idle_state(low_power_idle_state),
        .start_req(start_req), .stop_req(stop_req), .op_mode(op_mode), .iface_reset(iface_reset),
        .bus_event_irq(bus_event_irq), .shift_go(shift_go), .shift_abort(shift_abort),
        .shift_xfer_mode(shift_xfer_mode), .baud_clk_en(baud_clk_en), .iface_run(iface_run));

    sbsc_peer_model peer_u (.clk(clk), .rstn(rstn), .start_req(start_req), .stop_req(stop_req),
        .iface_reset(iface_reset), .shift_go(shift_go), .shift_abort(shift_abort), .op_mode(op_mode),
        .core_master(core_master), .core_transmit(core_transmit), .core_bus_busy(core_bus_busy),
        .core_byte_done(core_byte_done), .shift_xfer_busy(shift_xfer_busy), .shift_busy(shift_busy));

    always #5 clk = ~clk;

    // Pulse counters and the hang limit; pulses are sampled at the edge, so each is counted once.
    always @(posedge clk)
    begin
        n_start += (start_req === 1'b1);
        n_stop += (stop_req === 1'b1);
        n_rst += (iface_reset === 1'b1);
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            error_cnt++;
            give_verdict;
        end
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; plain writes only, never a read-modify-write on the shared offset.
    task wb(input logic w, input logic [15:0] a, input logic [7:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= sel_v;
        wb_dat_i <= {24'h0, d};
        @(posedge clk);
        while (wb_ack_o !== 1'b1)
            @(posedge clk);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task rdchk(input logic [15:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk("read data", rd, exp);
    endtask

    // Expected two-wire status: role, busy and pending-not bits over the event flags and last bit.
    function automatic logic [7:0] st_exp(input logic [3:0] hi, input logic [3:0] ev);
        return {hi, ev[2:0], ev[3]};
    endfunction

    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdchk(16'h490c, 8'h10);
        rdchk(16'h4910, 8'h00);
        rdchk(16'h4914, 8'h00);
        rdchk(16'h4a00, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, 16'h490c, {4'h0, 2'(i), 2'h0});
            repeat (2) @(posedge clk);
            chk("op_mode", {6'h0, op_mode}, (i == 3) ? 8'h02 : 8'(i));
        end
        $display("mode select done");
        s = n_start;
        wb(1'b1, 16'h490c, 8'h28);
        repeat (3) @(posedge clk);
        chk("start count", 8'(n_start - s), 8'h01);
        rdchk(16'h490c, 8'hf0);
        repeat (16) @(posedge clk);
        rdchk(16'h490c, 8'he0);
        chk("irq", {7'h0, bus_event_irq}, 8'h01);
        s = n_stop;
        wb(1'b1, 16'h490c, 8'h08);
        repeat (3) @(posedge clk);
        chk("stop count", 8'(n_stop - s), 8'h01);
        rdchk(16'h490c, 8'h10);
        chk("irq", {7'h0, bus_event_irq}, 8'h00);
        $display("start stop done");
        for (int k = 0; k < 8; k++)
        begin
            rnd = $random(seed);
            e = (k == 0) ? 4'hf : rnd[3:0];
            {rx_bit, ev_arb_lost, ev_addr_match, ev_general_call} <= e;
            rx_bit_strobe <= 1'b1;
            @(posedge clk);
            {ev_arb_lost, ev_addr_match, ev_general_call, rx_bit_strobe} <= 4'h0;
            repeat (2) @(posedge clk);
            rdchk(16'h490c, st_exp(4'h1, e));
            wb(1'b1, 16'h490c, 8'h08);
        end
        $display("event flags done");
        // A control write does not clear the last received bit; only the key reset does.
        {rx_bit, rx_bit_strobe} <= 2'h3;
        @(posedge clk);
        rx_bit_strobe <= 1'b0;
        s = n_rst;
        wb(1'b1, 16'h490c, 8'h09);
        wb(1'b1, 16'h490c, 8'h0a);
        wb(1'b1, 16'h490c, 8'h0a);
        wb(1'b1, 16'h490c, 8'h09);
        repeat (4) @(posedge clk);
        chk("key reset count", 8'(n_rst - s), 8'h01);
        chk("op_mode", {6'h0, op_mode}, 8'h02);
        rdchk(16'h490c, 8'h10);
        $display("key reset done");
        wb(1'b1, 16'h490c, 8'h04);
        wb(1'b1, 16'h4900, 8'h80);
        repeat (3) @(posedge clk);
        rdchk(16'h490c, 8'h0c);
        wb(1'b1, 16'h4900, 8'h00);
        repeat (3) @(posedge clk);
        rdchk(16'h490c, 8'h00);
        xm = 2'h0;
        foreach (st_codes[j])
        begin
            wb(1'b1, 16'h4900, {2'h0, st_codes[j], 4'h0});
            xm = (st_codes[j] == 2'h1) ? xm : st_codes[j];
            repeat (2) @(posedge clk);
            chk("xfer mode", {6'h0, shift_xfer_mode}, {6'h0, xm});
        end
        wb(1'b1, 16'h4900, 8'hc0);
        repeat (3) @(posedge clk);
        chk("go and abort", {6'h0, shift_go, shift_abort}, 8'h03);
        rdchk(16'h490c, 8'h00);
        $display("shift mode done");
        low_power_idle_state <= 1'b1;
        wb(1'b1, 16'h4910, 8'h00);
        wb(1'b1, 16'h4914, 8'h80);
        repeat (2) @(posedge clk);
        chk("run and clock", {6'h0, iface_run, baud_clk_en}, 8'h00);
        // A write with the low byte lane off is acknowledged and dropped.
        sel_v = 4'h0;
        wb(1'b1, 16'h4910, 8'h40);
        sel_v = 4'h1;
        rdchk(16'h4910, 8'h00);
        wb(1'b1, 16'h4910, 8'h40);
        repeat (2) @(posedge clk);
        chk("run and clock", {6'h0, iface_run, baud_clk_en}, 8'h03);
        rdchk(16'h4910, 8'h40);
        rdchk(16'h4914, 8'h80);
        low_power_idle_state <= 1'b0;
        wb(1'b1, 16'h4914, 8'h00);
        repeat (2) @(posedge clk);
        chk("run and clock", {6'h0, iface_run, baud_clk_en}, 8'h02);
        $display("rate registers done");
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
